// file: rtl/serial_rx_pkg.sv
// Constants shared by the serial receiver: frame layout, field codes, timing counts.
// Assumes a single 100 MHz clock and a bit-rate tick supplied from outside.
// Operation
// - Receiver enable hands the receive pin to the receiver as serial input.
// - Synchronous mode samples bits on the rising external transfer clock edges.
// - After start bit, sample and shift each bit up to first stop bit.
// - On first stop bit, move the whole frame into the receive buffer.
// - Unused upper data bits read as zero for 5 to 8 bit characters.
// - Ninth bit and error flags stored per entry; data read advances FIFO.
// - Receive complete flag is one while the buffer holds unread data.
// - Interrupt requested while flag, its enable and global enable are set.
// - Disabling the receiver flushes the buffer and clears receive complete.
// - Disabling is immediate, abandons the frame, releases the pin.
// - Error flags ignore software writes; software writes them as zero.
// - No interrupt comes from frame, overrun or parity error flags.
// - Frame error is the inverse of the first stop bit, whatever stop count.
// - Overrun set when FIFO full, shift register waiting and new start bit.
// - Overrun marks frames lost before the next frame read.
// - Overrun cleared when a frame moves from shift register into buffer.
// - Parity checked only if enable bit set; odd select picks the sense.
// - Parity error stored per character, valid until the data is read.
// - With parity checking disabled the parity error reads zero.
package serial_rx_pkg;
  localparam int          DATA_W        = 9;
  localparam int          FIFO_DEPTH    = 2;
  localparam logic [2:0]  SIZE_9BIT     = 3'h7;
  localparam logic [3:0]  BIT_CNT_W0    = 4'h0;
  localparam int          CLOCK_MHZ     = 100;
  localparam int          SYNC_STAGES   = 3;
  typedef enum logic [1:0] {
    st_idle   = 2'b00,
    st_data   = 2'b01,
    st_parity = 2'b11,
    st_stop   = 2'b10
  } rx_state_e;
endpackage

// file: rtl/serial_rx_sync.sv
// Three-stage input synchroniser with agreement of the last two stages.
// Assumes the input is asynchronous to i_clock.
`timescale 1ns/1ps
module serial_rx_sync
  import serial_rx_pkg::*;
(
  input  wire logic i_clock,   // System clock.
  input  wire logic i_reset,   // Asynchronous reset, active high.
  input  wire logic i_async,   // Raw pin level.
  input  wire logic i_init,    // Unused; the stages always reset high.
  output logic      o_level    // Filtered level.
);
  logic [SYNC_STAGES-1:0] stage;

  // The first stage only feeds the second, to contain metastability.
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      stage <= '1;
    end else begin
      stage <= {stage[SYNC_STAGES-2:0], i_async};
    end
  end

  // A change is accepted only once the last two stages agree.
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      o_level <= 1'b1;
    end else if (stage[2] == stage[1]) begin
      o_level <= stage[2];
    end
  end

  logic unused_init;
  assign unused_init = i_init;
endmodule

// file: rtl/serial_rx_fifo.sv
// Two-entry receive FIFO holding nine data bits and three error flags per entry.
// Assumes the writer never pushes while full; pop when empty is ignored.
`timescale 1ns/1ps
module serial_rx_fifo
  import serial_rx_pkg::*;
(
  input  wire logic              i_clock,   // System clock.
  input  wire logic              i_reset,   // Asynchronous reset, active high.
  input  wire logic              i_flush,   // Empty the FIFO at once.
  input  wire logic              i_push,    // Write one entry.
  input  wire logic [DATA_W+2:0] i_entry,   // Entry: flags then data.
  input  wire logic              i_pop,     // Advance to the next entry.
  output logic [DATA_W+2:0]      o_entry,   // Oldest entry.
  output logic                   o_empty,   // No unread entry.
  output logic                   o_full     // Both entries hold data.
);
  logic [DATA_W+2:0] mem [FIFO_DEPTH];
  logic              rd_ptr;
  logic              wr_ptr;
  logic [1:0]        count;

  // Entries leave in arrival order; a flush drops every pointer at once.
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      rd_ptr <= 1'b0;
      wr_ptr <= 1'b0;
      count  <= 2'h0;
    end else if (i_flush) begin
      rd_ptr <= 1'b0;
      wr_ptr <= 1'b0;
      count  <= 2'h0;
    end else begin
      if (i_push && !o_full) begin
        wr_ptr <= ~wr_ptr;
      end
      if (i_pop && !o_empty) begin
        rd_ptr <= ~rd_ptr;
      end
      count <= count + 2'((i_push && !o_full) ? 1 : 0) - 2'((i_pop && !o_empty) ? 1 : 0);
    end
  end

  // Storage carries no reset; only valid entries are ever read.
  always_ff @(posedge i_clock) begin
    if (i_push && !o_full) begin
      mem[wr_ptr] <= i_entry;
    end
  end

  assign o_entry = mem[rd_ptr];
  assign o_empty = (count == 2'h0);
  assign o_full  = (count == 2'h2);
endmodule

// file: rtl/serial_rx.sv
// Receive half of a serial port: shift register, error checks and two-entry buffer.
// Assumes a one-cycle bit tick at the centre of each bit in asynchronous mode;
// clock recovery and majority voting sit upstream of this block.
`timescale 1ns/1ps
module serial_rx
  import serial_rx_pkg::*;
(
  input  wire logic        i_clock,                       // System clock, 100 MHz.
  input  wire logic        i_reset,                       // Asynchronous reset, active high.
  input  wire logic        i_receiver_enable_bit,         // Receiver enable.
  input  wire logic        i_synchronous_mode,            // One selects the external transfer clock.
  input  wire logic        i_bit_tick,                    // Sample strobe from the baud unit.
  input  wire logic        i_external_transfer_clock_pin, // External transfer clock pin.
  input  wire logic        i_serial_input_pin,            // Serial data pin.
  input  wire logic [2:0]  i_character_size_field,        // Size code, 0..3 for 5..8, 7 for 9 bits.
  input  wire logic        i_parity_enable_bit,           // Parity checking on.
  input  wire logic        i_parity_odd_select_bit,       // Zero even, one odd.
  input  wire logic        i_stop_bit_count_select,       // Stop count, ignored by the receiver.
  input  wire logic        i_receive_complete_irq_enable, // Receive complete interrupt enable.
  input  wire logic        i_global_irq_enable,           // Global interrupt enable.
  input  wire logic        i_data_read,                   // Read strobe of the data register.
  output logic [7:0]       o_data_buffer_register,        // Low data bits of the oldest entry.
  output logic             o_received_ninth_bit,          // Ninth bit of the oldest entry.
  output logic             o_frame_error_flag,            // Frame error of the oldest entry.
  output logic             o_overrun_flag,                // Overrun of the oldest entry.
  output logic             o_parity_error_flag,           // Parity error of the oldest entry.
  output logic             o_receive_complete_flag,       // Unread data present.
  output logic             o_receive_complete_irq,        // Interrupt request.
  output logic             o_pin_override                 // Receiver owns the pin.
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers.

  logic rx_level;
  logic xck_level;
  logic xck_prev;

  serial_rx_sync u_sync_rx (
    .i_clock (i_clock),
    .i_reset (i_reset),
    .i_async (i_serial_input_pin),
    .i_init  (1'b1),
    .o_level (rx_level)
  );

  serial_rx_sync u_sync_xck (
    .i_clock (i_clock),
    .i_reset (i_reset),
    .i_async (i_external_transfer_clock_pin),
    .i_init  (1'b1),
    .o_level (xck_level)
  );

  // Edge detect on the filtered transfer clock, never on a raw stage.
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      xck_prev <= 1'b1;
    end else begin
      xck_prev <= xck_level;
    end
  end

  logic sample;
  // Synchronous mode samples on the rising transfer clock edge.
  assign sample = i_synchronous_mode ? (xck_level && !xck_prev) : i_bit_tick;

  // The pin belongs to the receiver only while it is enabled.
  assign o_pin_override = i_receiver_enable_bit;

  ////////////////////////////////////////////////////////////////////////////
  // Frame shifting.

  rx_state_e         state;
  logic [3:0]        bit_cnt;
  logic [DATA_W-1:0] shift;
  logic              par_acc;
  logic              par_bit;
  logic [3:0]        data_bits;

  // Size code 7 selects nine bits; codes 0..3 select five to eight.
  assign data_bits = (i_character_size_field == SIZE_9BIT) ? 4'h9
                                                           : (4'h5 + {2'h0, i_character_size_field[1:0]});

  logic start_seen;
  assign start_seen = (state == st_idle) && sample && !rx_level;

  // Bits arrive LSB first and are placed by index, so short characters keep zero tops.
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      state   <= st_idle;
      bit_cnt <= BIT_CNT_W0;
      shift   <= '0;
      par_acc <= 1'b0;
      par_bit <= 1'b0;
    end else if (!i_receiver_enable_bit) begin
      state   <= st_idle;
      bit_cnt <= BIT_CNT_W0;
    end else if (sample) begin
      case (state)
        st_idle: begin
          if (!rx_level) begin
            state   <= st_data;
            bit_cnt <= BIT_CNT_W0;
            shift   <= '0;
            par_acc <= 1'b0;
          end
        end
        st_data: begin
          shift[bit_cnt] <= rx_level;
          par_acc        <= par_acc ^ rx_level;
          bit_cnt        <= bit_cnt + 4'h1;
          if (bit_cnt == data_bits - 4'h1) begin
            state <= i_parity_enable_bit ? st_parity : st_stop;
          end
        end
        st_parity: begin
          par_bit <= rx_level;
          state   <= st_stop;
        end
        st_stop: begin
          state <= st_idle;
        end
        default: begin
          state <= st_idle;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Hand-off into the buffer.

  logic              frame_done;
  logic              frame_err;
  logic              parity_err;
  logic              hold_valid;
  logic [DATA_W+2:0] hold_entry;
  logic              lost;
  logic              fifo_empty;
  logic              fifo_full;
  logic [DATA_W+2:0] head;
  logic              pop;

  // A frame completes at its first stop bit; any second stop bit is ignored.
  assign frame_done = i_receiver_enable_bit && sample && (state == st_stop);
  assign frame_err  = !rx_level;
  // Even select expects an even count of ones including the parity bit.
  assign parity_err = i_parity_enable_bit && (par_acc ^ par_bit ^ i_parity_odd_select_bit);

  // A finished frame waits here while the FIFO is full, acting as the shift register.
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      hold_valid <= 1'b0;
      hold_entry <= '0;
    end else if (!i_receiver_enable_bit) begin
      hold_valid <= 1'b0;
    end else if (frame_done) begin
      hold_valid <= 1'b1;
      hold_entry <= {frame_err, 1'b0, parity_err, shift};
    end else if (hold_valid && !fifo_full) begin
      hold_valid <= 1'b0;
    end
  end

  // Overrun: buffer full, a frame waiting, and a new start bit; that frame is lost.
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      lost <= 1'b0;
    end else if (!i_receiver_enable_bit) begin
      lost <= 1'b0;
    end else if (start_seen && fifo_full && hold_valid) begin
      lost <= 1'b1;
    end else if (hold_valid && !fifo_full) begin
      lost <= 1'b0;
    end
  end

  logic              push;
  logic [DATA_W+2:0] push_entry;
  assign push = hold_valid && !fifo_full && i_receiver_enable_bit;
  // The overrun mark travels with the next frame that makes it into the buffer.
  assign push_entry = {hold_entry[DATA_W+2], lost, hold_entry[DATA_W:0]};
  assign pop  = i_data_read;

  serial_rx_fifo u_fifo (
    .i_clock (i_clock),
    .i_reset (i_reset),
    .i_flush (!i_receiver_enable_bit),
    .i_push  (push),
    .i_entry (push_entry),
    .i_pop   (pop),
    .o_entry (head),
    .o_empty (fifo_empty),
    .o_full  (fifo_full)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Read side; the host reads status before data since a read advances the head.

  logic show;
  // Disabling hides the head at once, in step with the flag, so no flushed entry lingers on the outputs.
  assign show = !fifo_empty && i_receiver_enable_bit;

  // Outputs are registered copies of the head entry, masked when nothing is held.
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      o_data_buffer_register  <= 8'h00;
      o_received_ninth_bit    <= 1'b0;
      o_frame_error_flag      <= 1'b0;
      o_overrun_flag          <= 1'b0;
      o_parity_error_flag     <= 1'b0;
      o_receive_complete_flag <= 1'b0;
    end else begin
      o_data_buffer_register  <= show ? head[7:0] : 8'h00;
      o_received_ninth_bit    <= show && head[8];
      o_frame_error_flag      <= show && head[DATA_W+2];
      o_overrun_flag          <= show && head[DATA_W+1];
      o_parity_error_flag     <= show && head[DATA_W];
      o_receive_complete_flag <= show;
    end
  end

  // Level request, no error sources feed it.
  assign o_receive_complete_irq = o_receive_complete_flag && i_receive_complete_irq_enable
                                  && i_global_irq_enable;

  logic unused_stop;
  assign unused_stop = i_stop_bit_count_select;
endmodule

// file: test/serial_rx_chk.sv
// Port checker for the serial receiver.
// Assumes a bind to serial_rx; it watches that module's ports only.
`timescale 1ns/1ps
module serial_rx_chk (
  input wire logic       i_clock, i_reset, i_receiver_enable_bit, i_synchronous_mode, i_bit_tick, // Controls.
  input wire logic       i_data_read, i_receive_complete_irq_enable, i_global_irq_enable, // Strobes and enables.
  input wire logic [7:0] o_data_buffer_register, // Head data.
  input wire logic       o_received_ninth_bit, o_frame_error_flag, o_overrun_flag, o_parity_error_flag, // Flags.
  input wire logic       o_receive_complete_flag, o_receive_complete_irq, o_pin_override // Status.
);
  logic [11:0] head;
  // The head entry is packed once so that each property stays short.
  assign head = {o_received_ninth_bit, o_frame_error_flag, o_overrun_flag, o_parity_error_flag, o_data_buffer_register};
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_reset);
  ////////////////////////////////////////
  a_pin_owner: assert property (o_pin_override == i_receiver_enable_bit)
    else $error("pin ownership differs from enable");
  a_irq_level: assert property (o_receive_complete_irq ==
    (o_receive_complete_flag && i_receive_complete_irq_enable && i_global_irq_enable))
    else $error("interrupt request mismatch");
  a_disable_flush: assert property ($fell(i_receiver_enable_bit) |=> (!o_receive_complete_flag)[*2])
    else $error("buffer not flushed on disable");
  a_off_empty: assert property (!i_receiver_enable_bit |=> head == 12'h000 && !o_receive_complete_flag)
    else $error("disabled receiver shows data");
  a_empty_zero: assert property (!o_receive_complete_flag |-> head == 12'h000)
    else $error("empty buffer shows data");
  a_flag_holds: assert property (!i_data_read ##1
    (o_receive_complete_flag && i_receiver_enable_bit && !i_data_read) |=> o_receive_complete_flag)
    else $error("flag dropped without a read");
  // A read moves the head two cycles later and a push may refill an emptied buffer, so three quiet cycles pin it down.
  a_head_stable: assert property (!i_data_read ##1 (o_receive_complete_flag && !i_data_read) ##1
    (i_receiver_enable_bit && !i_data_read) |=> $stable(head))
    else $error("head entry changed without a read");
  a_flag_after_stop: assert property ($rose(o_receive_complete_flag) && !$past(i_synchronous_mode, 2) |->
    $past(i_bit_tick, 2) || $past(i_bit_tick, 3) || $past(i_bit_tick, 4))
    else $error("flag rose without a stop sample");
  c_frame: cover property ($rose(o_receive_complete_flag));
  c_overrun: cover property (o_overrun_flag);
  c_parity: cover property (o_parity_error_flag);
  c_irq: cover property (o_receive_complete_irq);
endmodule
bind serial_rx serial_rx_chk i_chk (.i_clock, .i_reset, .i_receiver_enable_bit, .i_synchronous_mode, .i_bit_tick,
  .i_data_read, .i_receive_complete_irq_enable, .i_global_irq_enable, .o_data_buffer_register,
  .o_received_ninth_bit, .o_frame_error_flag, .o_overrun_flag, .o_parity_error_flag,
  .o_receive_complete_flag, .o_receive_complete_irq, .o_pin_override);

// file: test/serial_tx_model.sv
// Model of the remote transmitter that drives the receive line.
// Assumes the bench calls send; line idles high, strobes and clock rest between frames.
`timescale 1ns/1ps
module serial_tx_model (
  input  wire logic i_clock, // System clock.
  input  wire logic i_sync,  // One sends a transfer clock instead of ticks.
  output logic      o_line,  // Serial data line.
  output logic      o_tick,  // Bit centre strobe.
  output logic      o_xck    // Transfer clock.
);
  localparam int BIT_CYCLES = 16;
  // Idle levels from time zero.
  initial begin
    o_line = 1'b1;
    o_tick = 1'b0;
    o_xck = 1'b0;
  end
  // Start, data LSB first, optional parity, one stop; the centre strobe sits mid-bit,
  // well after the receiver's pin synchroniser has settled.
  task automatic send(input logic [8:0] d, input int n, input logic par_on, input logic par, input logic stop);
    logic [11:0] bits;
    int          len;
    bits = 12'h000;
    for (int k = 0; k < n; k++) bits[k+1] = d[k];
    len = n + 1;
    if (par_on) begin
      bits[len] = par;
      len++;
    end
    bits[len] = stop;
    for (int k = 0; k <= len; k++) begin
      for (int c = 0; c < BIT_CYCLES; c++) begin
        @(posedge i_clock);
        o_line <= bits[k];
        o_tick <= !i_sync && c == 8;
        o_xck <= i_sync && c >= 8;
      end
    end
    @(posedge i_clock);
    o_line <= 1'b1;
    o_tick <= 1'b0;
    o_xck <= 1'b0;
  endtask
endmodule

// file: test/serial_receiver_buffer_status_test.sv
// Self-checking bench for the serial receiver.
// Assumes serial_rx with its bound checker and the transmitter model.
`timescale 1ns/1ps
module serial_receiver_buffer_status_test import serial_rx_pkg::*; ;
  logic       clock, reset, en, sync_mode, par_on, par_odd, stop2, irq_en, gie, rd;
  logic [2:0] size;
  logic       line, tick, xck, ninth, fe, dor, pe, rxc, irq, owner;
  logic [7:0] data;
  int         error_cnt, tests_run, cycles;
  serial_rx i_dut (
    .i_clock(clock), .i_reset(reset), .i_receiver_enable_bit(en), .i_synchronous_mode(sync_mode),
    .i_bit_tick(tick), .i_external_transfer_clock_pin(xck), .i_serial_input_pin(line),
    .i_character_size_field(size), .i_parity_enable_bit(par_on), .i_parity_odd_select_bit(par_odd),
    .i_stop_bit_count_select(stop2), .i_receive_complete_irq_enable(irq_en), .i_global_irq_enable(gie),
    .i_data_read(rd), .o_data_buffer_register(data), .o_received_ninth_bit(ninth),
    .o_frame_error_flag(fe), .o_overrun_flag(dor), .o_parity_error_flag(pe),
    .o_receive_complete_flag(rxc), .o_receive_complete_irq(irq), .o_pin_override(owner));
  serial_tx_model i_tx (.i_clock(clock), .i_sync(sync_mode), .o_line(line), .o_tick(tick), .o_xck(xck));
  ////////////////////////////////////////
  // Free-running 100 MHz clock.
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // A hang is cut short well beyond the expected few thousand cycles.
  always @(posedge clock) begin
    cycles++;
    if (cycles == 10000) begin
      error_cnt++;
      give_verdict();
    end
  end
  task automatic check(input logic [11:0] got, input logic [11:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wait_rxc();
    for (int n = 0; n < 400 && rxc !== 1'b1; n++) @(negedge clock);
  endtask
  // Head is judged before the read strobe, because the strobe moves the buffer on.
  task automatic take(input logic [11:0] exp);
    wait_rxc();
    check({ninth, fe, dor, pe, data}, exp);
    @(posedge clock);
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    repeat (4) @(negedge clock);
  endtask
  ////////////////////////////////////////
  task automatic t_sizes();
    logic [2:0] codes[5] = '{3'h0, 3'h1, 3'h2, 3'h3, SIZE_9BIT};
    logic [8:0] m;
    int         n;
    foreach (codes[i]) begin
      n = (codes[i] == SIZE_9BIT) ? 9 : codes[i] + 5;
      m = 9'h1B5 & ((9'h001 << n) - 9'h001);
      @(posedge clock);
      size <= codes[i];
      gie <= codes[i][0];
      irq_en <= codes[i][1];
      i_tx.send(9'h1B5, n, 1'b0, 1'b0, 1'b1);
      wait_rxc();
      check(irq, codes[i][0] & codes[i][1]);
      take({m[8], 3'b000, m[7:0]});
      check(rxc, 1'b0);
    end
    $display("test sizes done");
  endtask
  task automatic t_parity();
    logic p;
    for (int i = 0; i < 8; i++) begin
      @(posedge clock);
      par_on <= i[2];
      par_odd <= i[1];
      stop2 <= i[0];
      p = ^8'h07 ^ i[1] ^ i[0];
      @(posedge clock);
      i_tx.send(9'h007, 8, i[2], p, i[1] ~^ i[0]);
      take({1'b0, ~(i[1] ~^ i[0]), 1'b0, i[2] & i[0], 8'h07});
    end
    $display("test parity done");
  endtask
  // Two frames fill the buffer, a third waits, a fourth start loses it.
  task automatic t_overrun();
    @(posedge clock);
    par_on <= 1'b0;
    i_tx.send(9'h011, 8, 1'b0, 1'b0, 1'b1);
    i_tx.send(9'h022, 8, 1'b0, 1'b0, 1'b1);
    i_tx.send(9'h033, 8, 1'b0, 1'b0, 1'b1);
    i_tx.send(9'h044, 8, 1'b0, 1'b0, 1'b1);
    take(12'h011);
    take(12'h022);
    take(12'h244);
    i_tx.send(9'h055, 8, 1'b0, 1'b0, 1'b1);
    take(12'h055);
    $display("test overrun done");
  endtask
  task automatic t_disable();
    i_tx.send(9'h05A, 8, 1'b0, 1'b0, 1'b1);
    fork
      i_tx.send(9'h0C3, 8, 1'b0, 1'b0, 1'b1);
      begin
        repeat (60) @(posedge clock);
        en <= 1'b0;
        repeat (2) @(negedge clock);
        check({rxc, owner}, 2'b00);
      end
    join
    @(posedge clock);
    en <= 1'b1;
    i_tx.send(9'h096, 8, 1'b0, 1'b0, 1'b1);
    take(12'h096);
    check({owner, rxc}, 2'b10);
    $display("test disable done");
  endtask
  task automatic t_sync();
    @(posedge clock);
    sync_mode <= 1'b1;
    @(posedge clock);
    i_tx.send(9'h0E7, 8, 1'b0, 1'b0, 1'b1);
    take(12'h0E7);
    @(posedge clock);
    sync_mode <= 1'b0;
    $display("test sync done");
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // Format is fixed before reset ends and before any frame is sent.
  initial begin
    {error_cnt, tests_run, cycles} = '0;
    {reset, en, irq_en, gie} = 4'hF;
    {sync_mode, par_on, par_odd, stop2, rd} = 5'h00;
    size = 3'h3;
    repeat (8) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    t_sizes();
    size <= 3'h3;
    t_parity();
    t_overrun();
    t_disable();
    t_sync();
    give_verdict();
  end
endmodule
